// ==== include/pmac_regs.svh ====
// Register offsets, field positions, reset values and codes of the
// package memory access checker.
// Assumes a 32-bit APB slave with byte addresses decoded on paddr[7:0].
`ifndef PMAC_REGS_SVH
`define PMAC_REGS_SVH

// Byte offsets of the software-visible registers.
`define PMAC_OFS_CTRL      8'h00
`define PMAC_OFS_STATUS    8'h04
`define PMAC_OFS_ATTR_SEL  8'h08
`define PMAC_OFS_ATTR_DATA 8'h0c
`define PMAC_OFS_TRAP_INFO 8'h10

// Field positions.
`define PMAC_CTRL_LOCK_BIT     0
`define PMAC_STAT_REFUSED_BIT  0
`define PMAC_STAT_TRAPPED_BIT  1
`define PMAC_STAT_LOCKED_BIT   2
`define PMAC_ATTR_PRIV_BIT     4
`define PMAC_TRAP_WRITE_BIT    16

// Package identities: zero names no package, 1..255 are real packages.
`define PMAC_PKG_NONE      8'h00
`define PMAC_PKG_OS        8'h01
`define PMAC_PKG_COUNT     256

// Effective rights codes.
`define PMAC_EAR_FULL_BOTH        3'h0
`define PMAC_EAR_FULL_SELF_RDX    3'h1
`define PMAC_EAR_READ_BOTH        3'h2
`define PMAC_EAR_FULL_SELF_ONLY   3'h3
`define PMAC_EAR_READ_SELF_ONLY   3'h4

// Manufacture defaults of the attribute table.
`define PMAC_DEF_RIGHTS    3'h3
`define PMAC_DEF_OS_RIGHTS 3'h0

`endif

// ==== include/pmac_pkg.sv ====
// Types shared by the package memory access checker.
// Assumes pmac_regs.svh supplies the numeric codes.
`include "pmac_regs.svh"

package pmac_pkg;

  // Effective rights setting of one package.
  typedef enum logic [2:0] {
    full_both            = `PMAC_EAR_FULL_BOTH,
    full_self_read_cross = `PMAC_EAR_FULL_SELF_RDX,
    read_both            = `PMAC_EAR_READ_BOTH,
    full_self_only       = `PMAC_EAR_FULL_SELF_ONLY,
    read_self_only       = `PMAC_EAR_READ_SELF_ONLY
  } pmac_rights_t;

  // Permission attributes held per package.
  typedef struct packed {
    logic         privileged;
    pmac_rights_t rights;
  } pmac_attr_t;

  // One core access request.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  execPkg;
    logic [7:0]  tgtPkg;
    logic [15:0] addr;
    logic [31:0] wdata;
  } pmac_req_t;

  // Access sequencer states.
  typedef enum logic [1:0] {
    PMAC_IDLE = 2'b00,
    PMAC_MEM  = 2'b01,
    PMAC_RESP = 2'b10
  } pmac_state_t;

endpackage

// ==== hw/pmac_rights_check.sv ====
// Combinational permission decision for one access.
// Assumes attributes of the executing and the targeted package are valid.
`timescale 1ns/1ps

module pmac_rights_check
  import pmac_pkg::*;
(
  input  wire pmac_attr_t execAttr,
  input  wire pmac_attr_t tgtAttr,
  input  wire logic [7:0] execPkg,
  input  wire logic [7:0] tgtPkg,
  input  wire logic       isWrite,
  output logic            allow
);

  logic samePkg;    // Access stays inside its own package.
  logic selfRd;     // Rights allow reading inside.
  logic selfWr;     // Rights allow writing inside.
  logic crossRd;    // Rights allow reading across.
  logic crossWr;    // Rights allow writing across.

  assign samePkg = (execPkg == tgtPkg);

  // Decode the target's rights into four permissions.
  always_comb begin
    selfRd  = 1'b0;
    selfWr  = 1'b0;
    crossRd = 1'b0;
    crossWr = 1'b0;
    case (tgtAttr.rights)
      full_both: begin
        selfRd  = 1'b1;
        selfWr  = 1'b1;
        crossRd = 1'b1;
        crossWr = 1'b1;
      end
      full_self_read_cross: begin
        selfRd  = 1'b1;
        selfWr  = 1'b1;
        crossRd = 1'b1;
      end
      read_both: begin
        selfRd  = 1'b1;
        crossRd = 1'b1;
      end
      full_self_only: begin
        selfRd = 1'b1;
        selfWr = 1'b1;
      end
      read_self_only: begin
        selfRd = 1'b1;
      end
      default: begin
        // Undefined codes grant nothing, so a corrupt entry fails closed except under the privileged override.
        selfRd = 1'b0;
      end
    endcase
  end

  // Final decision; an unassigned package never gets access.
  always_comb begin
    if (execPkg == `PMAC_PKG_NONE || tgtPkg == `PMAC_PKG_NONE) begin
      allow = 1'b0;
    end else if (execAttr.privileged && !tgtAttr.privileged) begin
      allow = 1'b1;
    end else if (samePkg) begin
      allow = isWrite ? selfWr : selfRd;
    end else begin
      allow = isWrite ? crossWr : crossRd;
    end
  end

endmodule

// ==== hw/pmac_attr_table.sv ====
// Per-package attribute store with three read ports and one write port.
// Assumes the writer has already checked the caller's privilege.
`timescale 1ns/1ps

module pmac_attr_table
  import pmac_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       wrEn,
  input  wire logic [7:0] wrIdx,
  input  wire pmac_attr_t wrAttr,
  input  wire logic [7:0] rdIdxA,
  input  wire logic [7:0] rdIdxB,
  input  wire logic [7:0] rdIdxC,
  output pmac_attr_t      rdAttrA,
  output pmac_attr_t      rdAttrB,
  output pmac_attr_t      rdAttrC
);

  pmac_attr_t tbl_reg  [`PMAC_PKG_COUNT]; // One entry per package.
  pmac_attr_t tbl_next [`PMAC_PKG_COUNT]; // Next contents.

  // Only the addressed entry changes on a write.
  always_comb begin
    for (int i = 0; i < `PMAC_PKG_COUNT; i++) begin
      tbl_next[i] = tbl_reg[i];
    end
    if (wrEn) begin
      tbl_next[wrIdx] = wrAttr;
    end
  end

  // Reset loads fixed defaults; package one holds the system software.
  // Flops rather than RAM, so the defaults exist without a boot copy.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `PMAC_PKG_COUNT; i++) begin
        tbl_reg[i] <= '{privileged: 1'b0,
                        rights: pmac_rights_t'(`PMAC_DEF_RIGHTS)};
      end
      tbl_reg[`PMAC_PKG_OS] <= '{privileged: 1'b1,
                        rights: pmac_rights_t'(`PMAC_DEF_OS_RIGHTS)};
    end else begin
      for (int i = 0; i < `PMAC_PKG_COUNT; i++) begin
        tbl_reg[i] <= tbl_next[i];
      end
    end
  end

  assign rdAttrA = tbl_reg[rdIdxA];
  assign rdAttrB = tbl_reg[rdIdxB];
  assign rdAttrC = tbl_reg[rdIdxC];

endmodule

// ==== hw/pmac_top.sv ====
// Package memory access checker: sits between the core and memory,
// lets allowed accesses through and traps denied ones.
// Assumes a core on mclk holding its request until coreReady, and a
// memory returning read data one cycle after its enable.
`timescale 1ns/1ps

// Function
// - Up to 255 protected packages supported.
// - Each package is privileged or regular.
// - Privileged code fully accesses regular packages.
// - Separate intra and inter package rights.
// - Five rights settings decode access permissions.
// - Denied access raises protection violation trap.
// - Every read and write is checked.
// - Only privileged software changes or accepts rules.
// - Decision computed in hardware per access.
// - Decide on executing area, target area, direction.
// - Denied access yields no usable result.
// - Defined defaults after reset, privileged override.
module pmac_top
  import pmac_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [7:0]  cfgExecPkg,
  input  wire pmac_req_t   coreReq,
  input  wire logic [31:0] memRdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             coreReady,
  output logic             coreDone,
  output logic             coreTrap,
  output logic [31:0]      coreRdata,
  output logic             memEn,
  output logic             memWe,
  output logic [15:0]      memAddr,
  output logic [31:0]      memWdata
);

  // Access sequencer state.
  pmac_state_t state_reg, state_next;
  pmac_req_t   req_reg, req_next;       // Captured request.
  logic        allow_reg, allow_next;   // Decision for the held request.
  logic        ready_reg, ready_next;
  logic        done_reg, done_next;
  logic        trap_reg, trap_next;
  logic [31:0] crd_reg, crd_next;       // Read data to the core.
  logic        men_reg, men_next;
  logic        mwe_reg, mwe_next;
  logic [15:0] madr_reg, madr_next;
  logic [31:0] mwd_reg, mwd_next;

  // Register file state.
  logic        lock_reg, lock_next;       // Rules finally accepted.
  logic        refused_reg, refused_next; // Sticky: a config write refused.
  logic        trapped_reg, trapped_next; // Sticky: a trap occurred.
  logic [7:0]  sel_reg, sel_next;         // Selected table entry.
  logic [16:0] tinfo_reg, tinfo_next;     // Last trap: write, exec, target.
  logic [31:0] prd_reg, prd_next;
  logic        prdy_reg, prdy_next;
  logic        perr_reg, perr_next;

  // Attribute table connections.
  pmac_attr_t execAttr;   // Attributes of the executing package.
  pmac_attr_t tgtAttr;    // Attributes of the target package.
  pmac_attr_t cfgAttr;    // Configuring package, or the selected entry.
  pmac_attr_t wrAttr;
  logic       tblWr;
  logic       decision;   // Live decision for the incoming request.
  logic       cfgPriv;    // The configuring software is privileged.
  logic       apbAccess;  // Access phase in progress, not yet answered.
  logic       apbWrite;
  logic       mapped;
  logic [7:0] cfgIdx;     // Table entry that the APB side looks at.

  pmac_attr_table u_table (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .wrEn    (tblWr),
    .wrIdx   (sel_reg),
    .wrAttr  (wrAttr),
    .rdIdxA  (coreReq.execPkg),
    .rdIdxB  (coreReq.tgtPkg),
    .rdIdxC  (cfgIdx),
    .rdAttrA (execAttr),
    .rdAttrB (tgtAttr),
    .rdAttrC (cfgAttr)
  );

  // Every package id 1..255 has its own entry; id zero never passes.
  pmac_rights_check u_check (
    .execAttr (execAttr),
    .tgtAttr  (tgtAttr),
    .execPkg  (coreReq.execPkg),
    .tgtPkg   (coreReq.tgtPkg),
    .isWrite  (coreReq.write),
    .allow    (decision)
  );

  // Access sequencer: take, issue to memory if allowed, then answer.
  always_comb begin
    state_next = state_reg;
    req_next   = req_reg;
    allow_next = allow_reg;
    ready_next = ready_reg;
    done_next  = 1'b0;
    trap_next  = 1'b0;
    crd_next   = crd_reg;
    men_next   = 1'b0;
    mwe_next   = 1'b0;
    madr_next  = madr_reg;
    mwd_next   = mwd_reg;
    case (state_reg)
      PMAC_IDLE: begin
        // No access reaches memory without passing the check.
        if (coreReq.valid && ready_reg) begin
          req_next   = coreReq;
          allow_next = decision;
          ready_next = 1'b0;
          men_next   = decision;
          mwe_next   = decision && coreReq.write;
          madr_next  = coreReq.addr;
          mwd_next   = decision ? coreReq.wdata : 32'h0000_0000;
          state_next = PMAC_MEM;
        end
      end
      PMAC_MEM: begin
        // Memory produces its data during this cycle.
        state_next = PMAC_RESP;
      end
      PMAC_RESP: begin
        // Done and trap share the cycle a granted access would end in.
        done_next  = 1'b1;
        trap_next  = !allow_reg;
        crd_next   = (allow_reg && !req_reg.write) ? memRdata
                                                   : 32'h0000_0000;
        ready_next = 1'b1;
        state_next = PMAC_IDLE;
      end
      default: begin
        state_next = PMAC_IDLE;
        ready_next = 1'b1;
      end
    endcase
  end

  // Registers of the access sequencer.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= PMAC_IDLE;
      req_reg   <= '0;
      allow_reg <= 1'b0;
      ready_reg <= 1'b1;
      done_reg  <= 1'b0;
      trap_reg  <= 1'b0;
      crd_reg   <= 32'h0000_0000;
      men_reg   <= 1'b0;
      mwe_reg   <= 1'b0;
      madr_reg  <= 16'h0000;
      mwd_reg   <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      req_reg   <= req_next;
      allow_reg <= allow_next;
      ready_reg <= ready_next;
      done_reg  <= done_next;
      trap_reg  <= trap_next;
      crd_reg   <= crd_next;
      men_reg   <= men_next;
      mwe_reg   <= mwe_next;
      madr_reg  <= madr_next;
      mwd_reg   <= mwd_next;
    end
  end

  // APB decode; one wait state so that every answer comes from a flop.
  assign apbAccess = psel && penable && !prdy_reg;
  assign apbWrite  = apbAccess && pwrite;
  assign cfgPriv   = cfgAttr.privileged;
  assign mapped    = (paddr == `PMAC_OFS_CTRL)     ||
                     (paddr == `PMAC_OFS_STATUS)   ||
                     (paddr == `PMAC_OFS_ATTR_SEL) ||
                     (paddr == `PMAC_OFS_ATTR_DATA)||
                     (paddr == `PMAC_OFS_TRAP_INFO);
  assign wrAttr    = '{privileged: pwdata[`PMAC_ATTR_PRIV_BIT],
                       rights: pmac_rights_t'(pwdata[2:0])};
  // Table writes need privilege and an unlocked rule set.
  assign tblWr     = apbWrite && (paddr == `PMAC_OFS_ATTR_DATA) &&
                     cfgPriv && !lock_reg;

  // Register file next values.
  always_comb begin
    lock_next    = lock_reg;
    refused_next = refused_reg;
    trapped_next = trapped_reg;
    sel_next     = sel_reg;
    tinfo_next   = tinfo_reg;
    prd_next     = prd_reg;
    prdy_next    = apbAccess;
    perr_next    = 1'b0;
    if (apbWrite) begin
      if (!mapped) begin
        perr_next = 1'b1;
      end else if (paddr == `PMAC_OFS_STATUS) begin
        // Write one to clear; an arriving event below still wins.
        if (pwdata[`PMAC_STAT_REFUSED_BIT]) begin
          refused_next = 1'b0;
        end
        if (pwdata[`PMAC_STAT_TRAPPED_BIT]) begin
          trapped_next = 1'b0;
        end
      end else if (paddr == `PMAC_OFS_TRAP_INFO) begin
        perr_next = 1'b1; // Read-only register.
      end else if (!cfgPriv ||
                   (lock_reg && paddr != `PMAC_OFS_ATTR_SEL)) begin
        // Regular software, or a CTRL or table write after acceptance, is refused.
        perr_next    = 1'b1;
        refused_next = 1'b1;
      end else if (paddr == `PMAC_OFS_CTRL) begin
        // Lock is write-once until reset: acceptance is final.
        lock_next = pwdata[`PMAC_CTRL_LOCK_BIT];
      end else if (paddr == `PMAC_OFS_ATTR_SEL) begin
        sel_next = pwdata[7:0];
      end
    end else if (apbAccess) begin
      case (paddr)
        `PMAC_OFS_CTRL: begin
          prd_next = {31'h0000_0000, lock_reg};
        end
        `PMAC_OFS_STATUS: begin
          prd_next = {29'h0000_0000, lock_reg, trapped_reg, refused_reg};
        end
        `PMAC_OFS_ATTR_SEL: begin
          prd_next = {24'h00_0000, sel_reg};
        end
        `PMAC_OFS_ATTR_DATA: begin
          prd_next = {27'h000_0000, cfgAttr.privileged, 1'b0,
                      cfgAttr.rights};
        end
        `PMAC_OFS_TRAP_INFO: begin
          prd_next = {15'h0000, tinfo_reg};
        end
        default: begin
          prd_next  = 32'h0000_0000;
          perr_next = 1'b1;
        end
      endcase
    end
    // Trap record; set wins over a same-cycle clear.
    if (state_reg == PMAC_RESP && !allow_reg) begin
      trapped_next = 1'b1;
      tinfo_next   = {req_reg.write, req_reg.execPkg, req_reg.tgtPkg};
    end
  end

  // One table port serves the APB side. A write needs the privilege of
  // the configuring package and a read needs the selected entry; no
  // transfer is both, so the port follows the direction of the transfer.
  // This spares a fourth read port on a table of 256 entries, and it
  // keeps the register file from reaching into the table's storage.
  assign cfgIdx = pwrite ? cfgExecPkg : sel_reg;

  // Registers of the register file.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lock_reg    <= 1'b0;
      refused_reg <= 1'b0;
      trapped_reg <= 1'b0;
      sel_reg     <= 8'h00;
      tinfo_reg   <= 17'h0_0000;
      prd_reg     <= 32'h0000_0000;
      prdy_reg    <= 1'b0;
      perr_reg    <= 1'b0;
    end else begin
      lock_reg    <= lock_next;
      refused_reg <= refused_next;
      trapped_reg <= trapped_next;
      sel_reg     <= sel_next;
      tinfo_reg   <= tinfo_next;
      prd_reg     <= prd_next;
      prdy_reg    <= prdy_next;
      perr_reg    <= perr_next;
    end
  end

  assign prdata    = prd_reg;
  assign pready    = prdy_reg;
  assign pslverr   = perr_reg;
  assign coreReady = ready_reg;
  assign coreDone  = done_reg;
  assign coreTrap  = trap_reg;
  assign coreRdata = crd_reg;
  assign memEn     = men_reg;
  assign memWe     = mwe_reg;
  assign memAddr   = madr_reg;
  assign memWdata  = mwd_reg;

endmodule

// ==== sim/pmac_top_sva.sv ====
// Checker of the core, memory and APB timing of the access checker.
// Assumes it is bound to pmac_top and sees only that module's ports.
`timescale 1ns/1ps

module pmac_top_sva
  import pmac_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [7:0]  cfgExecPkg,
  input wire pmac_req_t   coreReq,
  input wire logic [31:0] memRdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        coreReady,
  input wire logic        coreDone,
  input wire logic        coreTrap,
  input wire logic [31:0] coreRdata,
  input wire logic        memEn,
  input wire logic        memWe,
  input wire logic [15:0] memAddr,
  input wire logic [31:0] memWdata
);
  // All checks run on the core clock and pause while reset is low.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic takeNow;  // A request is taken when offered while the port is free.
  assign takeNow = coreReq.valid && coreReady;

  a_answer_three_cyc: assert property (takeNow |-> ##1
    (!coreReady && !coreDone) [*2] ##1 (coreDone && coreReady))
    else $error("core answer not three cycles after take");
  a_id_zero_trap: assert property (takeNow &&
    (coreReq.tgtPkg == 8'h00 || coreReq.execPkg == 8'h00) |-> ##3 coreTrap)
    else $error("package id zero not trapped");
  a_trap_with_done: assert property (coreTrap |-> coreDone)
    else $error("trap without answer");
  a_trap_no_memory: assert property (coreTrap |-> !$past(memEn, 2))
    else $error("trapped access reached memory");
  a_trap_no_data: assert property (coreTrap |-> coreRdata == 32'h0)
    else $error("trapped access returned data");
  a_mem_from_take: assert property (memEn |-> $past(takeNow) &&
    memAddr == $past(coreReq.addr) && memWe == $past(coreReq.write))
    else $error("memory access not tied to a taken request");
  a_mem_then_pass: assert property (memEn |-> ##2 coreDone && !coreTrap)
    else $error("allowed access not answered cleanly");
  a_write_data_pass: assert property (memEn && memWe |->
    memWdata == $past(coreReq.wdata))
    else $error("write data altered");
  a_read_data_pass: assert property (memEn && !memWe |->
    ##2 coreRdata == $past(memRdata))
    else $error("read data not returned");
  a_apb_one_wait: assert property (psel && $rose(penable) |->
    !pready ##1 pready)
    else $error("register access not one wait state");
endmodule

bind pmac_top pmac_top_sva u_pmac_top_sva (
  .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .cfgExecPkg(cfgExecPkg), .coreReq(coreReq), .memRdata(memRdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .coreReady(coreReady), .coreDone(coreDone), .coreTrap(coreTrap),
  .coreRdata(coreRdata), .memEn(memEn), .memWe(memWe),
  .memAddr(memAddr), .memWdata(memWdata));

// ==== sim/pmac_mem_model.sv ====
// Memory behind the checker: one word per low address byte.
// Assumes single-cycle memEn pulses; read data follows one cycle later.
`timescale 1ns/1ps

module pmac_mem_model (
  input  wire logic        mclk,
  input  wire logic        memEn,
  input  wire logic        memWe,
  input  wire logic [15:0] memAddr,
  input  wire logic [31:0] memWdata,
  output logic      [31:0] memRdata
);
  logic [31:0] store [256];  // Word store, seeded with a known pattern.

  initial begin
    for (int i = 0; i < 256; i++) store[i] = 32'ha5a50000 | 32'(i);
  end

  // Read data is valid for one cycle only; otherwise the bus flips every
  // cycle so that a stale word can never pass for a fresh one.
  always @(posedge mclk) begin
    if (memEn && memWe) store[memAddr[7:0]] <= memWdata;
    memRdata <= (memEn && !memWe) ? store[memAddr[7:0]] : ~memRdata;
  end
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench for the package memory access checker.
// Assumes pmac_top, the memory model and the bound checker are compiled.
`timescale 1ns/1ps
`include "pmac_regs.svh"

module tb_top
  import pmac_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst_n, psel, penable, pwrite, pready, pslverr;
  logic        coreReady, coreDone, coreTrap, memEn, memWe;
  logic [7:0]  paddr, cfgExecPkg;
  logic [15:0] memAddr;
  logic [31:0] pwdata, prdata, memRdata, coreRdata, memWdata;
  pmac_req_t   coreReq;
  int          n_fail, num_checks;
  int          cycles = 0;  // Cycle count for the hang guard.

  pmac_top u_pmac_top (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .cfgExecPkg(cfgExecPkg), .coreReq(coreReq), .memRdata(memRdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .coreReady(coreReady), .coreDone(coreDone), .coreTrap(coreTrap),
    .coreRdata(coreRdata), .memEn(memEn), .memWe(memWe),
    .memAddr(memAddr), .memWdata(memWdata));
  pmac_mem_model u_pmac_mem_model (.mclk(mclk), .memEn(memEn),
    .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
    .memRdata(memRdata));

  always #12.5 mclk = ~mclk;

  // The whole run needs under a thousand cycles; far more means a hang.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t ns got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic xe,
                     input logic [31:0] xd);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // The wait ends when pready is seen high; if it never is, only the bench's hang guard ends it.
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    chk({31'h0, pslverr}, {31'h0, xe});
    if (!w) chk(prdata, xd);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One core access, checked for trap and returned data.
  task automatic ca(input logic w, input logic [7:0] ex, input logic [7:0] tg,
                    input logic [15:0] a, input logic [31:0] d,
                    input logic xt, input logic [31:0] xd);
    @(posedge mclk);
    coreReq <= '{1'b1, w, ex, tg, a, d};
    do begin
      @(posedge mclk);
    end while (coreReady !== 1'b1);
    coreReq.valid <= 1'b0;
    do begin
      @(posedge mclk);
    end while (coreDone !== 1'b1);
    chk({31'h0, coreTrap}, {31'h0, xt});
    chk(coreRdata, xd);
  endtask

  task automatic t_defaults();
    apb(1'b1, `PMAC_OFS_ATTR_SEL, 32'h1, 1'b0, 32'h0);
    apb(1'b0, `PMAC_OFS_ATTR_DATA, 32'h0, 1'b0, 32'h10);
    apb(1'b1, `PMAC_OFS_ATTR_SEL, 32'h5, 1'b0, 32'h0);
    apb(1'b0, `PMAC_OFS_ATTR_DATA, 32'h0, 1'b0, 32'h3);
    $display("test defaults done");
  endtask

  // Every rights code on package 5, accessed from itself and from 6.
  task automatic t_rights();
    logic        iw, xr, xw;
    logic [31:0] ex;
    logic [15:0] a;
    for (int c = 0; c < 5; c++) begin
      apb(1'b1, `PMAC_OFS_ATTR_DATA, 32'(c), 1'b0, 32'h0);
      iw = (c != 2 && c != 4);
      xr = (c < 3);
      xw = (c == 0);
      a = 16'h0500 + 16'(c);
      ex = 32'ha5a50000 | 32'(c);
      ca(1'b1, 8'h05, 8'h05, a, 32'h1100 + c, !iw, 32'h0);
      if (iw) ex = 32'h1100 + c;
      ca(1'b1, 8'h06, 8'h05, a, 32'h2200 + c, !xw, 32'h0);
      if (xw) ex = 32'h2200 + c;
      ca(1'b0, 8'h05, 8'h05, a, 32'h0, 1'b0, ex);
      ca(1'b0, 8'h06, 8'h05, a, 32'h0, !xr, xr ? ex : 32'h0);
      ca(1'b0, 8'h01, 8'h05, a, 32'h0, 1'b0, ex);
    end
    // An undefined rights code must deny even a read inside the package.
    apb(1'b1, `PMAC_OFS_ATTR_DATA, 32'h7, 1'b0, 32'h0);
    ca(1'b0, 8'h05, 8'h05, 16'h0507, 32'h0, 1'b1, 32'h0);
    apb(1'b1, `PMAC_OFS_ATTR_DATA, 32'h4, 1'b0, 32'h0);
    $display("test rights done");
  endtask

  task automatic t_priv();
    ca(1'b1, 8'h01, 8'h05, 16'h0504, 32'h3300, 1'b0, 32'h0);
    ca(1'b0, 8'h05, 8'h05, 16'h0504, 32'h0, 1'b0, 32'h3300);
    ca(1'b1, 8'h05, 8'h00, 16'h0000, 32'h1, 1'b1, 32'h0);
    apb(1'b0, `PMAC_OFS_TRAP_INFO, 32'h0, 1'b0, 32'h10500);
    apb(1'b0, `PMAC_OFS_STATUS, 32'h0, 1'b0, 32'h2);
    apb(1'b1, `PMAC_OFS_STATUS, 32'h2, 1'b0, 32'h0);
    apb(1'b0, `PMAC_OFS_STATUS, 32'h0, 1'b0, 32'h0);
    $display("test privileged done");
  endtask

  // Regular software is refused; once locked, even privileged table writes are.
  task automatic t_guard();
    cfgExecPkg <= 8'h06;
    apb(1'b1, `PMAC_OFS_ATTR_SEL, 32'h7, 1'b1, 32'h0);
    apb(1'b1, `PMAC_OFS_CTRL, 32'h1, 1'b1, 32'h0);
    cfgExecPkg <= 8'h01;
    apb(1'b0, `PMAC_OFS_STATUS, 32'h0, 1'b0, 32'h1);
    apb(1'b1, 8'h14, 32'h0, 1'b1, 32'h0);
    apb(1'b1, `PMAC_OFS_STATUS, 32'h1, 1'b0, 32'h0);
    apb(1'b1, `PMAC_OFS_CTRL, 32'h1, 1'b0, 32'h0);
    apb(1'b1, `PMAC_OFS_ATTR_DATA, 32'h0, 1'b1, 32'h0);
    apb(1'b0, `PMAC_OFS_STATUS, 32'h0, 1'b0, 32'h5);
    $display("test guard done");
  endtask

  // A second reset must bring back the manufacture defaults.
  task automatic t_reset();
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    apb(1'b0, `PMAC_OFS_STATUS, 32'h0, 1'b0, 32'h0);
    apb(1'b1, `PMAC_OFS_ATTR_SEL, 32'h5, 1'b0, 32'h0);
    apb(1'b0, `PMAC_OFS_ATTR_DATA, 32'h0, 1'b0, 32'h3);
    $display("test reset done");
  endtask

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cfgExecPkg = 8'h01;
    coreReq = '0;
    n_fail = 0;
    num_checks = 0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    t_defaults();
    t_rights();
    t_priv();
    t_guard();
    t_reset();
    give_verdict();
  end
endmodule
